// ### pkg/lcae_pkg.sv
// Constants and carrier types for the line-cycle apparent energy accumulator.
// Assumes one clock domain; register offsets are byte addresses on AHB-Lite.
`default_nettype none
package lcae_pkg;
  ////////////////////////////////////////////////////////////////////////////
  localparam int ACC_W = 48;
  localparam int RES_W = 24;
  localparam int SMP_W = 24;
  localparam int DIV_W = 8;
  localparam int HC_W = 16;
  localparam int ST_W = 3;
  localparam int AW = 8;
  // Accumulation tick every four clocks
  localparam int TICK_CLKS = 4;
  localparam logic [1:0] TICK_LAST = 2'(TICK_CLKS - 1);
  localparam logic [5:0] DIV_STEPS = 6'h30;
  // Register byte offsets
  localparam logic [AW-1:0] OFS_RESULT = 8'h00;
  localparam logic [AW-1:0] OFS_LINE = 8'h04;
  localparam logic [AW-1:0] OFS_DIV = 8'h08;
  localparam logic [AW-1:0] OFS_HCC = 8'h0c;
  localparam logic [AW-1:0] OFS_STAT = 8'h10;
  localparam logic [AW-1:0] OFS_MASK = 8'h14;
  // Status and mask bit positions
  localparam int ST_CYC = 0;
  localparam int ST_HALF = 1;
  localparam int ST_OVF = 2;
  // Reset values and the NONSEQ transfer code
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam logic [HC_W-1:0] HCC_RST = 16'hffff;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [AW-1:0] rd_addr;
    logic [31:0] wdata;
  } lcae_bus_t;

  typedef struct packed {
    logic wr_pend;
    logic [AW-1:0] wr_addr;
    logic [31:0] rdata;
  } lcae_slv_st_t;

  typedef struct packed {
    logic busy;
    logic [5:0] step;
    logic [DIV_W:0] rem;
    logic [ACC_W-1:0] quo;
    logic [DIV_W-1:0] dvs;
    logic [RES_W-1:0] res;
    logic upd;
  } lcae_div_st_t;

  typedef struct packed {
    logic [1:0] tick_cnt;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] line_acc;
    logic [ACC_W-1:0] line_sum;
    logic [HC_W-1:0] hc_cnt;
    logic [DIV_W-1:0] div;
    logic [HC_W-1:0] hcc;
    logic [RES_W-1:0] res;
    logic [RES_W-1:0] line_res;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] mask;
    logic period_end;
    logic cal_pulse;
  } lcae_top_st_t;
endpackage
`default_nettype wire

// ### rtl/lcae_ahb_slave.sv
// AHB-Lite slave front end: address decode, write strobe, registered read data.
// Assumes single word transfers; read data word is supplied by the owner.
`timescale 1ns/1ps
`default_nettype none
module lcae_ahb_slave import lcae_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] rd_word,
  output lcae_bus_t bus,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  lcae_slv_st_t st_q, st_d;
  logic req;

  ////////////////////////////////////////////////////////////////////////////
  // Stretch transfers while frozen so none is lost
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;
  assign req = hsel && hready && ce && htrans == HTRANS_NONSEQ;

  always_comb begin
    st_d = st_q;
    bus.rd = req && !hwrite;
    bus.wr = st_q.wr_pend && ce;
    // Own read address, so a write data phase and a read address phase can share a cycle
    bus.addr = st_q.wr_addr;
    bus.rd_addr = haddr[AW-1:0];
    bus.wdata = hwdata;
    if (ce) begin
      st_d.wr_pend = req && hwrite;
      if (req) begin
        st_d.wr_addr = haddr[AW-1:0];
      end
      if (bus.rd) begin
        st_d.rdata = rd_word;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule // lcae_ahb_slave
`default_nettype wire

// ### rtl/lcae_divider.sv
// Free-running restoring divider: 48-bit dividend by 8-bit divisor.
// Snapshots its inputs when idle; a zero divisor divides by one.
`timescale 1ns/1ps
`default_nettype none
module lcae_divider import lcae_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ACC_W-1:0] dividend,
  input wire logic [DIV_W-1:0] divisor,
  output logic [RES_W-1:0] quotient_hi,
  output logic upd
);
  lcae_div_st_t st_q, st_d;
  logic [DIV_W:0] trial;

  ////////////////////////////////////////////////////////////////////////////
  assign quotient_hi = st_q.res;
  assign upd = st_q.upd;

  always_comb begin
    st_d = st_q;
    trial = {st_q.rem[DIV_W-1:0], st_q.quo[ACC_W-1]};
    if (ce) begin
      st_d.upd = 1'b0;
      if (!st_q.busy) begin
        st_d.busy = 1'b1;
        st_d.step = '0;
        st_d.rem = '0;
        st_d.quo = dividend;
        st_d.dvs = (divisor == '0) ? 8'h01 : divisor;
      end else begin
        st_d.quo = {st_q.quo[ACC_W-2:0], 1'b0};
        if (trial >= {1'b0, st_q.dvs}) begin
          st_d.rem = trial - {1'b0, st_q.dvs};
          st_d.quo[0] = 1'b1;
        end else begin
          st_d.rem = trial;
        end
        st_d.step = st_q.step + 6'h01;
        if (st_q.step == DIV_STEPS - 6'h01) begin
          st_d.busy = 1'b0;
          st_d.upd = 1'b1;
          st_d.res = st_d.quo[ACC_W-1 -: RES_W];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule // lcae_divider
`default_nettype wire

// ### rtl/lcae_top.sv
// Apparent energy accumulator with line-cycle mode, AHB-Lite registers and irq.
// Assumes power samples, zero-crossing and active pulse are synchronous to sys_clk.
//
// How it works
// - One apparent power sample is added to the accumulator every four clocks.
// - The internal accumulator is 48 bits wide and wraps past all ones.
// - The visible result is 24 bits; with a divisor of zero or one it overflows past its all-ones value.
// - A divisor above one scales the result down in proportion; it still wraps when the accumulator wraps.
// - Line accumulation always runs over a counted number of half line cycles.
// - The half-cycle count comes from an unsigned 16-bit setting, up to 65535.
// - The line period is shared with the active energy path via a period pulse.
// - Each period end sets the cycle-done flag and, if unmasked, asserts irq_n low.
// - The line result uses the same path and LSB weight as the free-running result.
// - The calibration pulse output follows active energy only.
// - No reactive gain or offset correction exists in this block.
// - The divisor is 8 bits unsigned and zero divides by one.
// - The visible result is the upper 24 bits of the divided accumulator, unsigned.
`timescale 1ns/1ps
`default_nettype none
module lcae_top import lcae_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [SMP_W-1:0] power_sample,
  input wire logic zero_cross,
  input wire logic active_pulse_in,
  output logic calibration_pulse_out,
  output logic line_period_end,
  output logic irq_n
);
  lcae_top_st_t st_q, st_d;
  lcae_bus_t bus;
  logic [31:0] rd_word;
  logic tick;
  logic last_half;
  logic [ACC_W-1:0] sample_ext;
  logic [ACC_W-1:0] div_in [2];
  logic [RES_W-1:0] div_out [2];
  logic div_upd [2];
  logic half_evt;
  logic ovf_evt;
  logic [ST_W-1:0] evt;

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode for the read data mux; the status clear compares rd_addr on its own
  function automatic logic [31:0] reg_word(input logic [AW-1:0] a,
                                          input lcae_top_st_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      OFS_RESULT: w = {8'h00, s.res};
      OFS_LINE: w = {8'h00, s.line_res};
      OFS_DIV: w = {24'h00_0000, s.div};
      OFS_HCC: w = {16'h0000, s.hcc};
      OFS_STAT: w = {29'h0000_0000, s.stat};
      OFS_MASK: w = {29'h0000_0000, s.mask};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  lcae_ahb_slave u_slave (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .rd_word(rd_word),
    .bus(bus),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp)
  );

  assign rd_word = reg_word(bus.rd_addr, st_q);

  ////////////////////////////////////////////////////////////////////////////
  // Same divider for both sums keeps their LSB weight equal
  assign div_in[0] = st_q.acc;
  assign div_in[1] = st_q.line_sum;

  for (genvar i = 0; i < 2; i++) begin : g_div
    lcae_divider u_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .dividend(div_in[i]),
      .divisor(st_q.div),
      .quotient_hi(div_out[i]),
      .upd(div_upd[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Signed add of the power word, as the power path is twos complement
  assign sample_ext = {{(ACC_W - SMP_W){power_sample[SMP_W-1]}}, power_sample};
  assign tick = st_q.tick_cnt == TICK_LAST;
  // Setting of zero or one closes the period on every crossing
  assign last_half = zero_cross && (st_q.hc_cnt + 16'h0001 >= st_q.hcc);

  // Unsigned result: half full on bit 23 rising, overflow on wrap
  assign half_evt = div_upd[0] && !st_q.res[RES_W-1] && div_out[0][RES_W-1];
  assign ovf_evt = div_upd[0] && (div_out[0] < st_q.res);

  always_comb begin
    evt = '0;
    evt[ST_CYC] = ce && last_half;
    evt[ST_HALF] = ce && half_evt;
    evt[ST_OVF] = ce && ovf_evt;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.period_end = 1'b0;
      // Only active energy pulses reach the pulse pin
      st_d.cal_pulse = active_pulse_in;
      st_d.tick_cnt = st_q.tick_cnt + 2'h1;

      if (tick) begin
        st_d.acc = st_q.acc + sample_ext;
        st_d.line_acc = st_q.line_acc + sample_ext;
      end

      if (zero_cross) begin
        st_d.hc_cnt = st_q.hc_cnt + 16'h0001;
      end
      if (last_half) begin
        st_d.hc_cnt = '0;
        st_d.line_sum = st_d.line_acc;
        st_d.line_acc = '0;
        st_d.period_end = 1'b1;
      end

      if (div_upd[0]) begin
        st_d.res = div_out[0];
      end
      if (div_upd[1]) begin
        st_d.line_res = div_out[1];
      end

      if (bus.wr) begin
        case (bus.addr)
          OFS_DIV: st_d.div = bus.wdata[DIV_W-1:0];
          OFS_HCC: st_d.hcc = bus.wdata[HC_W-1:0];
          OFS_MASK: st_d.mask = bus.wdata[ST_W-1:0];
          default: st_d.mask = st_q.mask;
        endcase
      end

      // Read clears status; a same-cycle event still lands
      if (bus.rd && bus.rd_addr == OFS_STAT) begin
        st_d.stat = '0;
      end
      st_d.stat = st_d.stat | evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.div <= DIV_RST;
      st_q.hcc <= HCC_RST;
      st_q.mask <= MASK_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // No reactive gain or offset stage lives here; the host corrects it
  assign calibration_pulse_out = st_q.cal_pulse;
  assign line_period_end = st_q.period_end;
  assign irq_n = ~|(st_q.stat & st_q.mask);
endmodule // lcae_top
`default_nettype wire

// ### verification/lcae_top_assertions.sv
// Port checker for the apparent energy accumulator top.
// Assumes one clock domain; bound to every lcae_top instance.
`timescale 1ns/1ps
`default_nettype none
module lcae_top_assertions import lcae_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic zero_cross,
  input wire logic active_pulse_in,
  input wire logic calibration_pulse_out,
  input wire logic line_period_end,
  input wire logic irq_n
);
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic req = hsel && ce && hready && htrans == HTRANS_NONSEQ;
  ////////////////////////////////////////////////////////////////////////////
  a_ready_ce: assert property (hreadyout == ce)
    else $error("hreadyout differs from ce");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_pulse_copy: assert property (ce && !rst |=> calibration_pulse_out == $past(active_pulse_in))
    else $error("pulse output not a copy of active pulse");
  // A frozen clock enable may hold the pulse, so only its first cycle is traced
  a_end_cause: assert property (line_period_end && $past(ce) |-> $past(zero_cross) || $past(zero_cross, 2))
    else $error("period end without zero crossing");
  a_end_single: assert property (line_period_end && ce |=> !line_period_end)
    else $error("period end longer than one cycle");
  // Irq may only release after a status read or a mask write
  a_irq_release: assert property ($rose(irq_n) |-> $past(req) || $past(req, 2) || $past(req, 3))
    else $error("irq released without access");
  a_rst_quiet: assert property ($fell(rst) |-> irq_n && !line_period_end && hrdata == 32'h0)
    else $error("outputs not quiet after reset");
  a_rdata_hold: assert property (!$past(req && !hwrite) |-> $stable(hrdata))
    else $error("read data changed without read");
endmodule // lcae_top_assertions
bind lcae_top lcae_top_assertions u_chk (.sys_clk(sys_clk), .rst(rst), .ce(ce), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .zero_cross(zero_cross), .active_pulse_in(active_pulse_in),
  .calibration_pulse_out(calibration_pulse_out), .line_period_end(line_period_end),
  .irq_n(irq_n));
`default_nettype wire

// ### verification/lcae_line_src.sv
// Line model: zero-crossing pulses a fixed spacing apart.
// Assumes the bench clock; quiet while en is low.
`timescale 1ns/1ps
`default_nettype none
module lcae_line_src #(parameter int SPACE = 400) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic en,
  output logic zero_cross
);
  int cnt_q;
  // Never back to back, so one pulse means one half cycle
  always_ff @(posedge sys_clk) begin
    if (rst || !en) begin
      cnt_q <= 0;
      zero_cross <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == SPACE - 1) ? 0 : cnt_q + 1;
      zero_cross <= (cnt_q == SPACE - 1);
    end
  end
endmodule // lcae_line_src
`default_nettype wire

// ### verification/test_lcae_top.sv
// Self-checking bench: AHB-Lite master, line model, queued read checks.
// Assumes zero-wait slave answers while ce is high; ce dropped once to stretch a read.
`timescale 1ns/1ps
`default_nettype none
module test_lcae_top import lcae_pkg::*;;
  typedef struct {logic [31:0] e; logic [31:0] m; logic [31:0] t;} lcae_note_t;
  localparam logic [23:0] PWR = 24'h7fffff;
  logic sys_clk, rst, ce, hsel, hwrite, active_pulse_in, zero_en, rd_dp;
  logic [31:0] haddr, hwdata, r;
  logic [1:0] htrans;
  logic [23:0] power_sample;
  wire logic hreadyout, hresp, zero_cross, cal_out, line_period_end, irq_n;
  wire logic [31:0] hrdata;
  int fails, total_checks, cyc;
  lcae_note_t notes[$];
  ////////////////////////////////////////////////////////////////////////////
  lcae_top dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .power_sample(power_sample),
    .zero_cross(zero_cross), .active_pulse_in(active_pulse_in),
    .calibration_pulse_out(cal_out), .line_period_end(line_period_end), .irq_n(irq_n));
  lcae_line_src #(.SPACE(400)) u_line (.sys_clk(sys_clk), .rst(rst), .en(zero_en),
    .zero_cross(zero_cross));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic [31:0] t);
    notes.push_back('{e, m, t});
    xfer(1'b0, a, 32'h0);
  endtask
  // Period of two half cycles is 800 clocks, so 200 ticks; tick phase gives one LSB slack
  task automatic line_run(input longint d, input logic irq_exp);
    repeat (2) @(posedge sys_clk iff line_period_end === 1'b1);
    repeat (110) @(posedge sys_clk);
    rd(OFS_LINE, 32'((longint'(200) * PWR / d) >> 24), 32'hffffffff, 32'h1);
    chk(32'(irq_n), 32'(irq_exp));
    rd(OFS_STAT, 32'h1, 32'h1, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq_n), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    active_pulse_in <= 1'($urandom);
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  always @(posedge sys_clk) begin
    lcae_note_t n;
    logic [31:0] v;
    if (rd_dp && hreadyout) begin
      n = notes.pop_front();
      v = hrdata & n.m;
      total_checks++;
      if ((v ^ v) !== 32'h0 || v < n.e - n.t || v > n.e + n.t) begin
        fails++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, v, n.e);
      end
    end
    if (hreadyout) rd_dp = hsel && htrans == HTRANS_NONSEQ && !hwrite && !rst;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {hsel, hwrite, active_pulse_in, zero_en, rd_dp} = 5'h0;
    {haddr, hwdata, r} = '0;
    htrans = 2'h0;
    power_sample = 24'h0;
    void'($urandom(87156));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 7; i++) rd(8'(4 * i), (i == 3) ? 32'hffff : 32'h0, '1, 0);
    xfer(1'b1, OFS_DIV, 32'h1ff);
    rd(OFS_DIV, 32'hff, '1, 0);
    xfer(1'b1, OFS_HCC, 32'h12345);
    rd(OFS_HCC, 32'h2345, '1, 0);
    xfer(1'b1, OFS_RESULT, '1);
    rd(OFS_RESULT, 32'h0, '1, 0);
    r = $urandom;
    xfer(1'b1, OFS_MASK, r);
    rd(OFS_MASK, r & 32'h7, '1, 0);
    xfer(1'b1, OFS_MASK, 32'h1);
    xfer(1'b1, OFS_DIV, 32'h0);
    xfer(1'b1, OFS_HCC, 32'h2);
    power_sample <= PWR;
    zero_en <= 1'b1;
    line_run(1, 1'b0);
    // Freeze well away from a crossing; a read issued while frozen must wait
    ce <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(32'(hreadyout), 32'h0);
    fork
      rd(OFS_DIV, 32'h0, '1, 0);
      begin
        repeat (5) @(posedge sys_clk);
        ce <= 1'b1;
      end
    join
    xfer(1'b1, OFS_MASK, 32'h0);
    xfer(1'b1, OFS_DIV, 32'h3);
    line_run(3, 1'b1);
    give_verdict();
  end
endmodule // test_lcae_top
`default_nettype wire
